// ### design/pad_decoder.v
// Socket array address decoder with a programmable lookup table
// Assumes an AHB-Lite master on clk; bus addresses arrive on clk too
`timescale 1ns/100ps
`include "pad_consts.vh"

module pad_decoder
#(
  parameter TBL_DEPTH = 512
)
(
  input wire clk,
  input wire rst,
  input wire [21:0] mem_addr,
  input wire mem_valid,
  input wire [1:0] pattern_sel_pin,
  output reg [7:0] pair_en_q,
  output reg mem_respond_q,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp
);

  // ==========================================
  // Pattern select jumpers
  wire [1:0] pattern_sel;

  pad_sync3 #(.WIDTH(2)) u_sel_sync
  (
    .clk(clk),
    .rst(rst),
    .din(pattern_sel_pin),
    .dout(pattern_sel)
  );

  // ==========================================
  // Lookup table storage: {range, code} per entry
  reg [3:0] tbl_q [0:TBL_DEPTH-1];
  reg [2:0] ctrl_q;
  reg [8:0] tbl_idx_q;
  reg [21:0] probe_q;

  wire dec_en;
  assign dec_en = ctrl_q[`PAD_CTRL_EN_BIT];

  // ==========================================
  // Lookup and boot window detection
  wire [8:0] lut_index;
  wire [3:0] lut_entry;
  wire lut_range;
  wire [2:0] lut_code;
  wire [12:0] boot_field;
  wire boot_hit;

  // Hardware jumpers pick the pattern; the control select field is only stored and read back
  assign lut_index = {pattern_sel, mem_addr[`PAD_SEG_HI:`PAD_SEG_LO]};
  assign lut_entry = tbl_q[lut_index];
  assign lut_range = lut_entry[`PAD_ENTRY_RANGE_BIT];
  assign lut_code = lut_entry[2:0];
  assign boot_field = mem_addr[`PAD_BOOT_HI:`PAD_BOOT_LO];
  assign boot_hit = (boot_field == `PAD_BOOT_WIN_A) || (boot_field == `PAD_BOOT_WIN_B);

  // Part size only moves which address bits address inside a pair; the
  // table repeats the code over 2 or 4 entries so low bits never matter
  reg [2:0] sel_code;
  reg sel_en;

  always @*
  begin
    sel_code = 3'h0;
    sel_en = 1'b0;
    if (mem_valid && dec_en)
    begin
      if (boot_hit)
      begin
        sel_code = `PAD_BOOT_PAIR;
        sel_en = 1'b1;
      end
      else if (!lut_range && (lut_code != `PAD_BOOT_PAIR))
      begin
        sel_code = lut_code;
        sel_en = 1'b1;
      end
      // Range flag set: no pair, no response
    end
  end

  wire [7:0] onehot;

  pad_onehot u_onehot
  (
    .code(sel_code),
    .en(sel_en),
    .onehot(onehot)
  );

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pair_en_q <= 8'h00;
      mem_respond_q <= 1'b0;
    end
    else
    begin
      pair_en_q <= onehot;
      mem_respond_q <= sel_en;
    end
  end

  // ==========================================
  // AHB-Lite slave, zero wait states
  reg dp_wr_q;
  reg dp_rd_q;
  reg [11:0] dp_addr_q;

  wire ap_valid;
  assign ap_valid = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dp_wr_q <= 1'b0;
      dp_rd_q <= 1'b0;
      dp_addr_q <= 12'h000;
    end
    else if (hready)
    begin
      dp_wr_q <= ap_valid && hwrite;
      dp_rd_q <= ap_valid && !hwrite;
      dp_addr_q <= haddr[11:0];
    end
  end

  // Table writes; reset leaves every entry out of range
  integer k;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= `PAD_CTRL_RST;
      tbl_idx_q <= 9'h000;
      probe_q <= 22'h000000;
      for (k = 0; k < TBL_DEPTH; k = k + 1)
        tbl_q[k] <= `PAD_ENTRY_RST;
    end
    else if (dp_wr_q)
    begin
      case (dp_addr_q)
        `PAD_REG_CTRL: ctrl_q <= hwdata[2:0];
        `PAD_REG_TBL_IDX: tbl_idx_q <= hwdata[8:0];
        `PAD_REG_TBL_DATA: tbl_q[tbl_idx_q] <= hwdata[3:0];
        `PAD_REG_PROBE: probe_q <= hwdata[21:0];
        default: ;
      endcase
    end
  end

  // ==========================================
  // Refused access and misuse capture
  // Sticky flags for software; when a new event and a clear land in one
  // cycle the event wins, so nothing is lost between read and clear
  wire miss_wr;
  wire miss_event;
  wire guard_event;
  wire moved_event;
  reg miss_flag_q;
  reg guard_flag_q;
  reg moved_flag_q;
  reg [21:0] miss_addr_q;
  reg [1:0] sel_prev_q;

  assign miss_wr = dp_wr_q && (dp_addr_q == `PAD_REG_MISS);
  assign miss_event = mem_valid && dec_en && !sel_en;
  // A boot code written into the lookup is suppressed at decode time;
  // flag it so a bad table is seen rather than silently missing
  assign guard_event = dp_wr_q && (dp_addr_q == `PAD_REG_TBL_DATA) &&
    !hwdata[`PAD_ENTRY_RANGE_BIT] && (hwdata[2:0] == `PAD_BOOT_PAIR);
  // Jumpers should be static; accesses around a move may hit either pattern
  assign moved_event = dec_en && (pattern_sel != sel_prev_q);

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      miss_flag_q <= 1'b0;
      guard_flag_q <= 1'b0;
      moved_flag_q <= 1'b0;
      miss_addr_q <= 22'h000000;
      sel_prev_q <= 2'h0;
    end
    else
    begin
      sel_prev_q <= pattern_sel;
      if (miss_event)
      begin
        miss_flag_q <= 1'b1;
        miss_addr_q <= mem_addr;
      end
      else if (miss_wr && hwdata[`PAD_MISS_FLAG_BIT])
        miss_flag_q <= 1'b0;
      if (guard_event)
        guard_flag_q <= 1'b1;
      else if (miss_wr && hwdata[`PAD_GUARD_FLAG_BIT])
        guard_flag_q <= 1'b0;
      if (moved_event)
        moved_flag_q <= 1'b1;
      else if (miss_wr && hwdata[`PAD_MOVED_FLAG_BIT])
        moved_flag_q <= 1'b0;
    end
  end

  // ==========================================
  // Per-pair enable counters
  // Saturating, not wrapping, so a long run never reads back as a small
  // count; a pair enabled in the clearing cycle counts as one
  localparam CNT_W = 8;

  wire cnt_clear;
  wire [8*CNT_W-1:0] pair_count;

  assign cnt_clear = dp_wr_q && (dp_addr_q == `PAD_REG_CNT_LO);

  genvar p;
  generate
    for (p = 0; p < 8; p = p + 1)
    begin : g_cnt
      reg [CNT_W-1:0] cnt_q;

      always @(posedge clk or posedge rst)
      begin
        if (rst)
          cnt_q <= {CNT_W{1'b0}};
        else if (cnt_clear)
          cnt_q <= {{(CNT_W-1){1'b0}}, onehot[p]};
        else if (onehot[p] && (cnt_q != {CNT_W{1'b1}}))
          cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end

      assign pair_count[p*CNT_W +: CNT_W] = cnt_q;
    end
  endgenerate

  // ==========================================
  // Refused access counter
  // Saturates like the pair counters; cleared by any write to it
  reg [CNT_W-1:0] miss_cnt_q;
  wire miss_cnt_clear;

  assign miss_cnt_clear = dp_wr_q && (dp_addr_q == `PAD_REG_MISS_CNT);

  always @(posedge clk or posedge rst)
  begin
    if (rst)
      miss_cnt_q <= {CNT_W{1'b0}};
    else if (miss_cnt_clear)
      miss_cnt_q <= {{(CNT_W-1){1'b0}}, miss_event};
    else if (miss_event && (miss_cnt_q != {CNT_W{1'b1}}))
      miss_cnt_q <= miss_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
  end

  // Probe: what the decoder would do with a given address now
  wire [8:0] probe_index;
  wire [3:0] probe_entry;
  wire [12:0] probe_boot;
  wire probe_boot_hit;
  assign probe_index = {pattern_sel, probe_q[`PAD_SEG_HI:`PAD_SEG_LO]};
  assign probe_entry = tbl_q[probe_index];
  assign probe_boot = probe_q[`PAD_BOOT_HI:`PAD_BOOT_LO];
  assign probe_boot_hit = (probe_boot == `PAD_BOOT_WIN_A) || (probe_boot == `PAD_BOOT_WIN_B);

  // Same precedence as the live path but not gated by the enable, so a
  // table can be checked before decoding is turned on
  reg [2:0] probe_code;
  reg probe_respond;

  always @*
  begin
    probe_code = 3'h0;
    probe_respond = 1'b0;
    if (probe_boot_hit)
    begin
      probe_code = `PAD_BOOT_PAIR;
      probe_respond = 1'b1;
    end
    else if (!probe_entry[`PAD_ENTRY_RANGE_BIT] && (probe_entry[2:0] != `PAD_BOOT_PAIR))
    begin
      probe_code = probe_entry[2:0];
      probe_respond = 1'b1;
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
      hrdata <= 32'h00000000;
    else if (ap_valid && !hwrite)
    begin
      case (haddr[11:0])
        `PAD_REG_CTRL: hrdata <= {29'h0, ctrl_q};
        `PAD_REG_STATUS: hrdata <= {20'h0, mem_respond_q, pair_en_q, 1'b0, pattern_sel};
        `PAD_REG_TBL_IDX: hrdata <= {23'h0, tbl_idx_q};
        `PAD_REG_TBL_DATA: hrdata <= {28'h0, tbl_q[tbl_idx_q]};
        `PAD_REG_PROBE:
          hrdata <= {22'h0, probe_respond, probe_code, probe_boot_hit, probe_entry, 1'b0};
        `PAD_REG_MISS: hrdata <= {miss_flag_q, guard_flag_q, moved_flag_q, 7'h00, miss_addr_q};
        `PAD_REG_CNT_LO: hrdata <= pair_count[31:0];
        `PAD_REG_CNT_HI: hrdata <= pair_count[63:32];
        `PAD_REG_MISS_CNT: hrdata <= {24'h0, miss_cnt_q};
        // Unmapped offsets read as zero
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

endmodule // pad_decoder

// ### design/pad_consts.vh
// Constants for the socket array address decoder
// Included by the decoder and the bench, not by the onehot or sync files; definitions only
`ifndef PAD_CONSTS_VH
`define PAD_CONSTS_VH

// ==========================================
// Register byte addresses
`define PAD_REG_CTRL 12'h000
`define PAD_REG_STATUS 12'h004
`define PAD_REG_TBL_IDX 12'h008
`define PAD_REG_TBL_DATA 12'h00c
`define PAD_REG_PROBE 12'h010
`define PAD_REG_MISS 12'h014
`define PAD_REG_CNT_LO 12'h018
`define PAD_REG_CNT_HI 12'h01c
`define PAD_REG_MISS_CNT 12'h020

// ==========================================
// Field positions
`define PAD_CTRL_SEL_LO 0
`define PAD_CTRL_SEL_HI 1
`define PAD_CTRL_EN_BIT 2
`define PAD_ENTRY_RANGE_BIT 3
`define PAD_SEG_LO 12
`define PAD_SEG_HI 18
`define PAD_BOOT_LO 9
`define PAD_BOOT_HI 21
`define PAD_MISS_FLAG_BIT 31
`define PAD_GUARD_FLAG_BIT 30
`define PAD_MOVED_FLAG_BIT 29

// ==========================================
// Reset values and fixed codes
`define PAD_CTRL_RST 3'h0
`define PAD_ENTRY_RST 4'h8
`define PAD_BOOT_WIN_A 13'h1ffb
`define PAD_BOOT_WIN_B 13'h1ff5
`define PAD_BOOT_PAIR 3'h7
`define PAD_SEG_ALL_ONES 7'h7f

`endif

// ### design/pad_onehot.v
// 3-to-8 one-hot socket pair enable
// Combinational; driven by the lookup code and a master enable
`timescale 1ns/100ps
module pad_onehot
(
  input wire [2:0] code,
  input wire en,
  output wire [7:0] onehot
);

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_dec
      localparam [2:0] IDX = i;
      assign onehot[i] = en & (code == IDX);
    end
  endgenerate

endmodule // pad_onehot

// ### design/pad_sync3.v
// Three-flop synchroniser for a level from outside the clock domain
// Output changes only when the second and third stages agree
`timescale 1ns/100ps
module pad_sync3
#(
  parameter WIDTH = 2
)
(
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= {WIDTH{1'b0}};
      s2_q <= {WIDTH{1'b0}};
      s3_q <= {WIDTH{1'b0}};
      dout <= {WIDTH{1'b0}};
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        dout <= s3_q;
    end
  end

endmodule // pad_sync3

// ### test/pad_decoder_properties.sv
// Port checker for the decoder
// Bound to every pad_decoder; sees only its ports
`timescale 1ns/100ps
module pad_checker
(
  input wire clk,
  input wire rst,
  input wire [21:0] mem_addr,
  input wire mem_valid,
  input wire [7:0] pair_en_q,
  input wire mem_respond_q,
  input wire hreadyout,
  input wire hresp
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  wire boot = mem_valid && (mem_addr[21:9] == 13'h1ffb || mem_addr[21:9] == 13'h1ff5);
  AST_RDY: assert property (hreadyout) else $error("ready low");
  AST_OKAY: assert property (!hresp) else $error("bad resp");
  AST_ONEHOT: assert property ($onehot0(pair_en_q)) else $error("two pairs");
  AST_RESP: assert property (mem_respond_q == |pair_en_q) else $error("resp");
  AST_BOOT: assert property (boot |=> pair_en_q inside {8'h00, 8'h80}) else $error("boot");
  AST_BOOT_ONLY: assert property (pair_en_q[7] |-> $past(boot)) else $error("lookup");
  AST_IDLE: assert property (!mem_valid |=> pair_en_q == 8'h00) else $error("idle");
  AST_QUIET: assert property (!mem_valid [*2] |-> !mem_respond_q) else $error("quiet");
  cover property (pair_en_q[7]);
  cover property (pair_en_q[4]);
  cover property (mem_valid ##1 !mem_respond_q);
endmodule // pad_checker
bind pad_decoder pad_checker u_chk (.clk(clk), .rst(rst), .mem_addr(mem_addr),
  .mem_valid(mem_valid), .pair_en_q(pair_en_q), .mem_respond_q(mem_respond_q),
  .hreadyout(hreadyout), .hresp(hresp));

// ### test/pad_bus_master.sv
// Memory-side bus master model
// Assumes one access at a time, called by the bench
`timescale 1ns/100ps
module pad_bus_master
(
  input wire clk,
  output reg [21:0] mem_addr = 22'h0,
  output reg mem_valid = 1'b0
);
  task access(input [21:0] a);
    @(posedge clk);
    mem_valid <= 1'b1;
    mem_addr <= a;
    @(posedge clk);
    mem_valid <= 1'b0;
    // Released address must not look valid
    mem_addr <= ~a;
    #1;
  endtask
endmodule // pad_bus_master

// ### test/prom_array_address_decoder_test.sv
// Bench: table patterns, part sizes, boot windows
// Assumes pad_bus_master drives the memory side
`timescale 1ns/100ps
`include "pad_consts.vh"
module prom_array_address_decoder_test;
  reg clk = 1'b0, rst = 1'b1, hwrite = 1'b0;
  reg [1:0] pattern_sel_pin = 2'h0, htrans = 2'h0;
  reg [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  wire [31:0] hrdata;
  wire hreadyout, mem_respond_q, mem_valid;
  wire [7:0] pair_en_q;
  wire [21:0] mem_addr;
  integer fail_count = 0, comparisons = 0, cyc = 0, k;
  always #5 clk = ~clk;
  pad_bus_master u_mst (.clk(clk), .mem_addr(mem_addr), .mem_valid(mem_valid));
  pad_decoder dut (.clk(clk), .rst(rst), .mem_addr(mem_addr), .mem_valid(mem_valid),
    .pattern_sel_pin(pattern_sel_pin), .pair_en_q(pair_en_q), .mem_respond_q(mem_respond_q),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp());
  task chk(input string n, input [31:0] e, input [31:0] g);
    comparisons = comparisons + 1;
    fail_count = fail_count + (g !== e);
    if (g !== e)
      $display("mismatch %s expected %h seen %h", n, e, g);
  endtask
  task ahb(input w, input [11:0] a, input [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task put(input [8:0] i, input [3:0] e);
    ahb(1'b1, `PAD_REG_TBL_IDX, {23'h0, i});
    ahb(1'b1, `PAD_REG_TBL_DATA, {28'h0, e});
  endtask
  task acc(input [21:0] a, input [7:0] e);
    u_mst.access(a);
    chk("pair_en_q", {24'h0, e}, {24'h0, pair_en_q});
    chk("mem_respond_q", {31'h0, |e}, {31'h0, mem_respond_q});
  endtask
  task t_small;
    ahb(1'b0, `PAD_REG_TBL_DATA, 32'h0);
    chk("tbl_data", {28'h0, `PAD_ENTRY_RST}, rd);
    acc(22'h0, 8'h00);
    for (k = 0; k < 4; k = k + 1)
      put(k[8:0], k[3:0]);
    ahb(1'b1, `PAD_REG_CTRL, 32'h4);
    for (k = 0; k < 4; k = k + 1)
      acc({3'h0, k[6:0], 12'hffe}, 8'h01 << k);
    acc(22'h4000, 8'h00);
    acc(22'h7f000, 8'h00);
    $display("t_small done");
  endtask
  task t_big;
    pattern_sel_pin <= 2'h3;
    for (k = 0; k < 4; k = k + 1)
      put({2'h3, k[6:0]}, 4'h4);
    put(9'h184, 4'h5);
    put(9'h185, 4'h5);
    put(9'h186, 4'h7);
    for (k = 0; k < 6; k = k + 1)
      acc({3'h0, k[6:0], 12'h0}, k < 4 ? 8'h10 : 8'h20);
    acc(22'h6000, 8'h00);
    $display("t_big done");
  endtask
  task t_boot;
    acc(22'o17773000, 8'h80);
    acc(22'o17765777, 8'h80);
    acc(22'o17766000, 8'h00);
    $display("t_boot done");
  endtask
  task t_stats;
    ahb(1'b0, `PAD_REG_CNT_LO, 32'h0);
    chk("cnt_lo", 32'h01010101, rd);
    ahb(1'b0, `PAD_REG_CNT_HI, 32'h0);
    chk("cnt_hi", 32'h02000204, rd);
    ahb(1'b0, `PAD_REG_MISS_CNT, 32'h0);
    chk("miss_cnt", 32'h4, rd);
    ahb(1'b0, `PAD_REG_MISS, 32'h0);
    chk("miss", {3'h7, 7'h0, 22'o17766000}, rd);
    ahb(1'b1, `PAD_REG_PROBE, 32'h0);
    ahb(1'b0, `PAD_REG_PROBE, 32'h0);
    chk("probe_lut", 32'h308, rd);
    ahb(1'b1, `PAD_REG_PROBE, {10'h0, 22'o17773000});
    ahb(1'b0, `PAD_REG_PROBE, 32'h0);
    chk("probe_boot", 32'h3f0, rd);
    ahb(1'b1, `PAD_REG_MISS, 32'he0000000);
    ahb(1'b1, `PAD_REG_CNT_LO, 32'h0);
    ahb(1'b1, `PAD_REG_MISS_CNT, 32'h0);
    ahb(1'b0, `PAD_REG_MISS, 32'h0);
    chk("miss_clr", {10'h0, 22'o17766000}, rd);
    ahb(1'b0, `PAD_REG_CNT_HI, 32'h0);
    chk("cnt_clr", 32'h0, rd);
    ahb(1'b0, `PAD_REG_MISS_CNT, 32'h0);
    chk("miss_cnt_clr", 32'h0, rd);
    $display("t_stats done");
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard, far above the 120 or so cycles needed
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    fail_count = fail_count + (cyc == 3000);
    if (cyc == 3000)
      results;
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_small;
    t_big;
    t_boot;
    t_stats;
    results;
  end
endmodule // prom_array_address_decoder_test
